// >>> jk_seq_pkg.sv
// Constants for the registered logic sequencer; its product-term cell uses none of them.
// Assumes word-addressed Avalon-MM access; every offset below is a word index.
package jk_seq_pkg;

  // ==========================================================================
  // Array sizes
  localparam int NUM_IN    = 4;   // Dedicated inputs
  localparam int NUM_BIO   = 4;   // Bidirectional combinational lines
  localparam int NUM_FF    = 8;   // State flip-flops
  localparam int NUM_VAR   = 16;  // Term inputs: inputs, lines, state bits
  localparam int NUM_LOGIC = 32;  // Shared logic terms
  localparam int NUM_CTL   = 13;  // Control terms
  localparam int NUM_TERM  = 45;  // All product terms
  localparam int ADDR_W    = 7;

  // ==========================================================================
  // Word indices (byte address is four times the index)
  localparam int IDX_TERM0  = 0;   // 32 logic term link words
  localparam int IDX_CTL0   = 32;  // 13 control term link words
  localparam int IDX_JMASK0 = 45;  // 8 J (or D/T) OR masks
  localparam int IDX_KMASK0 = 53;  // 8 K OR masks
  localparam int IDX_BMASK0 = 61;  // 4 OR masks for the lines
  localparam int IDX_CIN    = 65;  // Terms feeding the complement NOR
  localparam int IDX_CUSE   = 66;  // Terms gated by the complement output
  localparam int IDX_MODE   = 67;  // Two mode bits per flip-flop
  localparam int IDX_PINCFG = 68;  // Line polarity and output selects
  localparam int IDX_STATUS = 69;  // Read-only live state
  localparam int NUM_CFG    = 69;  // Writable words

  // ==========================================================================
  // Link word fields: [15:0] true links, [31:16] complement links
  localparam int LINK_TRUE_LSB = 0;
  localparam int LINK_COMP_LSB = 16;
  localparam int PINCFG_POL_LSB = 0;
  localparam int PINCFG_OE_LSB  = 4;

  // Control term positions
  localparam int CTL_PRESET_LO = 0;  // Preset, flip-flops 0..3
  localparam int CTL_RESET_LO  = 1;
  localparam int CTL_PRESET_HI = 2;  // Preset, flip-flops 4..7
  localparam int CTL_RESET_HI  = 3;
  localparam int CTL_FC        = 4;  // Dynamic J-K/D select
  localparam int CTL_DIR0      = 5;  // Line drive enables, 4 terms
  localparam int CTL_LOAD0     = 9;  // Load controls, one per flip-flop pair

  // ==========================================================================
  // Values after reset (unprogrammed: term and OR mask links intact, complement masks clear)
  localparam logic [31:0] RST_LINK   = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ORMASK = 32'hFFFFFFFF;
  localparam logic [31:0] RST_CMASK  = 32'h00000000;
  localparam logic [31:0] RST_MODE   = 32'h00000000;
  localparam logic [31:0] RST_PINCFG = 32'h00000FF0;
  localparam logic [7:0]  Q_RESET    = 8'h00;
  localparam logic [7:0]  PIN_RESET  = 8'hFF;
  localparam logic [31:0] UNMAPPED   = 32'h00000000;

  typedef enum logic [1:0] {
    MODE_D   = 2'h0,
    MODE_JK  = 2'h1,
    MODE_JKD = 2'h2,
    MODE_T   = 2'h3
  } ffmode_t;

endpackage : jk_seq_pkg

// >>> product_term.sv
// One AND gate of the array with its true/complement links and complement gate.
// Assumes link bits are 1 while the link is intact (connected).
`timescale 1ns/10ps
module product_term (
  input  wire logic [15:0] vars,      // Term inputs
  input  wire logic [15:0] trueLink,  // Intact true links
  input  wire logic [15:0] compLink,  // Intact complement links
  input  wire logic        useComp,   // Term includes the complement output
  input  wire logic        compIn,    // Complement array output
  output logic             base,      // AND without the complement term
  output logic             term       // Full product term
);
  // Both links intact forces the term low
  assign base = &((vars | ~trueLink) & (~vars | ~compLink));
  assign term = base & (~useComp | compIn);
endmodule : product_term

// >>> programmable_jk_register_sequencer.sv
// Programmable registered logic sequencer: 8 state flip-flops fed by a term array.
// Assumes all pins synchronous to core_clk; configuration loaded over Avalon-MM.
//
// Overview of operation
// - Eight state flip-flops on registered pins, four inputs, four bidirectional lines.
// - Flip-flops change only on the rising clock; usable as input, output or both.
// - Power-up forces every registered pin to read one without a clock.
// - Each term takes true or inverted inputs, lines, states; logic terms also the complement term.
// - Excitations are ORs of selected terms from a shared pool of thirty-two.
// - Four dedicated terms give preset and reset, independent of programmed logic.
// - Preset with reset reads high; last control released sets the final value.
// - Each line has its own OR and selectable polarity, AND-OR or AND-NOR.
// - Load term high, outputs off: forced pin value loads on the clock edge.
// - Diagnostic mode loads pins into flip-flops regardless of logic; lines three-stated.
// - Unconfigured: preset, reset and all transition terms stay inactive.
// - Default D-type; may select J-K only or J-K/D switched by a term.
// - Unconfigured: lines are inputs, registered pins are outputs.
// - Load and output select terms choose pin or array load and pin drive.
// - The same term relationships apply in D and T modes.
// - At power-on state bits are zero so registered pins read one.
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module programmable_jk_register_sequencer (
  input  wire logic        core_clk,     // Clock, rising edge
  input  wire logic        resetn,       // Asynchronous reset, active low
  input  wire logic [6:0]  address,      // Avalon word address
  input  wire logic        read,         // Avalon read request
  input  wire logic        write,        // Avalon write request
  input  wire logic [31:0] writedata,    // Avalon write data
  input  wire logic [3:0]  byteenable,   // Avalon byte lanes
  output logic      [31:0] readdata,     // Avalon read data
  output logic             waitrequest,  // Avalon stall
  input  wire logic [3:0]  dinPin,       // Dedicated inputs
  input  wire logic [3:0]  bioIn,        // Line levels
  output logic      [3:0]  bioOut,       // Line drive values
  output logic      [3:0]  bioOe,        // Line drive enables
  input  wire logic [7:0]  regIn,        // Registered pin levels
  output logic      [7:0]  regOut,       // Registered pin drive values
  output logic      [7:0]  regOe,        // Registered pin drive enables
  input  wire logic        oeN,          // Output enable, active low
  input  wire logic        diagMode      // Elevated level on the enable pin
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [jk_seq_pkg::NUM_CFG-1:0][31:0] cfg;
    logic [7:0]  q;
    logic [7:0]  regOut;
    logic [7:0]  regOe;
    logic [3:0]  bioOut;
    logic [3:0]  bioOe;
    logic        waitrequest;
    logic [31:0] readdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic [jk_seq_pkg::NUM_TERM-1:0] baseT;
  logic [jk_seq_pkg::NUM_TERM-1:0] termT;
  logic [jk_seq_pkg::NUM_TERM-1:0] useLink;
  logic [jk_seq_pkg::NUM_VAR-1:0]  vars;
  logic [31:0]                     logicT;
  logic [jk_seq_pkg::NUM_CTL-1:0]  ctl;
  logic                            compArr;
  logic [7:0]                      jIn;
  logic [7:0]                      kIn;
  logic [3:0]                      bSum;
  logic [3:0]                      pol;
  logic [7:0]                      drive;
  logic [7:0]                      loadPin;
  logic [7:0]                      presetF;
  logic [7:0]                      resetF;

  // ==========================================================================
  // Functions
  function automatic logic orTerms(input logic [31:0] t, input logic [31:0] m);
    orTerms = |(t & m);
  endfunction : orTerms

  function automatic logic jkNext(input logic q, input logic j, input logic k);
    case ({j, k})
      2'b00:   jkNext = q;
      2'b01:   jkNext = 1'b0;
      2'b10:   jkNext = 1'b1;
      default: jkNext = ~q;
    endcase
  endfunction : jkNext

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    mergeBytes = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        mergeBytes[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction : mergeBytes

  function automatic logic [31:0] readWord(input state_t s, input logic [6:0] a,
                                           input logic [31:0] stat);
    if (int'(a) < jk_seq_pkg::NUM_CFG) begin
      readWord = s.cfg[a];
    end else if (int'(a) == jk_seq_pkg::IDX_STATUS) begin
      readWord = stat;
    end else begin
      readWord = jk_seq_pkg::UNMAPPED;
    end
  endfunction : readWord

  // ==========================================================================
  // Term array
  assign vars    = {st.q, bioIn, dinPin};
  assign useLink = {13'h0000, st.cfg[jk_seq_pkg::IDX_CUSE]};
  // Complement NOR reads the base terms so it cannot loop through itself
  assign compArr = ~|(baseT[31:0] & st.cfg[jk_seq_pkg::IDX_CIN]);

  genvar gt;
  generate
    for (gt = 0; gt < jk_seq_pkg::NUM_TERM; gt++) begin : g_term
      product_term u_term (
        .vars     (vars),
        .trueLink (st.cfg[gt][jk_seq_pkg::LINK_TRUE_LSB +: 16]),
        .compLink (st.cfg[gt][jk_seq_pkg::LINK_COMP_LSB +: 16]),
        .useComp  (useLink[gt]),
        .compIn   (compArr),
        .base     (baseT[gt]),
        .term     (termT[gt])
      );
    end
  endgenerate

  assign logicT = termT[31:0];
  assign ctl    = termT[jk_seq_pkg::NUM_TERM-1:jk_seq_pkg::NUM_LOGIC];
  assign pol    = st.cfg[jk_seq_pkg::IDX_PINCFG][jk_seq_pkg::PINCFG_POL_LSB +: 4];

  genvar gf;
  generate
    for (gf = 0; gf < jk_seq_pkg::NUM_FF; gf++) begin : g_ff
      assign jIn[gf] = orTerms(logicT, st.cfg[jk_seq_pkg::IDX_JMASK0 + gf]);
      assign kIn[gf] = orTerms(logicT, st.cfg[jk_seq_pkg::IDX_KMASK0 + gf]);
      assign presetF[gf] = (gf < 4) ? ctl[jk_seq_pkg::CTL_PRESET_LO]
                                    : ctl[jk_seq_pkg::CTL_PRESET_HI];
      assign resetF[gf]  = (gf < 4) ? ctl[jk_seq_pkg::CTL_RESET_LO]
                                    : ctl[jk_seq_pkg::CTL_RESET_HI];
      // Pin drives only with the enable low and the output select set
      assign drive[gf]   = ~oeN & st.cfg[jk_seq_pkg::IDX_PINCFG][jk_seq_pkg::PINCFG_OE_LSB + gf];
      // The outside holds this flip-flop's transition terms low meanwhile
      assign loadPin[gf] = ctl[jk_seq_pkg::CTL_LOAD0 + gf / 2] & ~drive[gf];
    end
  endgenerate

  genvar gb;
  generate
    for (gb = 0; gb < jk_seq_pkg::NUM_BIO; gb++) begin : g_bio
      assign bSum[gb] = orTerms(logicT, st.cfg[jk_seq_pkg::IDX_BMASK0 + gb]);
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    jk_seq_pkg::ffmode_t mode;
    logic                nq;
    next_st = st;
    mode    = jk_seq_pkg::MODE_D;
    nq      = 1'b0;

    // Bus slave: accept on the first edge, answer with waitrequest low one cycle
    if ((read || write) && st.waitrequest) begin
      next_st.waitrequest = 1'b0;
      next_st.readdata    = readWord(st, address, {8'h00, regIn, dinPin, bioIn, st.q});
    end else begin
      next_st.waitrequest = 1'b1;
    end
    if (write && !st.waitrequest && int'(address) < jk_seq_pkg::NUM_CFG) begin
      next_st.cfg[address] = mergeBytes(st.cfg[address], writedata, byteenable);
    end

    for (int f = 0; f < jk_seq_pkg::NUM_FF; f++) begin
      mode = jk_seq_pkg::ffmode_t'(st.cfg[jk_seq_pkg::IDX_MODE][2*f +: 2]);
      if (diagMode) begin
        nq = ~regIn[f];
      end else if (presetF[f]) begin
        nq = 1'b1;
      end else if (resetF[f]) begin
        nq = 1'b0;
      end else if (loadPin[f]) begin
        nq = ~regIn[f];
      end else begin
        case (mode)
          jk_seq_pkg::MODE_D:   nq = jIn[f];
          jk_seq_pkg::MODE_JK:  nq = jkNext(st.q[f], jIn[f], kIn[f]);
          jk_seq_pkg::MODE_JKD: nq = ctl[jk_seq_pkg::CTL_FC] ? jIn[f]
                                     : jkNext(st.q[f], jIn[f], kIn[f]);
          default:              nq = st.q[f] ^ jIn[f];
        endcase
      end
      next_st.q[f]      = nq;
      next_st.regOut[f] = ~nq;
      next_st.regOe[f]  = drive[f] & ~diagMode;
    end

    for (int b = 0; b < jk_seq_pkg::NUM_BIO; b++) begin
      next_st.bioOut[b] = bSum[b] ^ pol[b];
      next_st.bioOe[b]  = ctl[jk_seq_pkg::CTL_DIR0 + b] & ~diagMode;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < jk_seq_pkg::NUM_CFG; i++) begin
        if (i >= jk_seq_pkg::IDX_JMASK0 && i < jk_seq_pkg::IDX_CIN) begin
          st.cfg[i] <= jk_seq_pkg::RST_ORMASK;
        end else if (i == jk_seq_pkg::IDX_CIN || i == jk_seq_pkg::IDX_CUSE) begin
          st.cfg[i] <= jk_seq_pkg::RST_CMASK;
        end else if (i == jk_seq_pkg::IDX_MODE) begin
          st.cfg[i] <= jk_seq_pkg::RST_MODE;
        end else if (i == jk_seq_pkg::IDX_PINCFG) begin
          st.cfg[i] <= jk_seq_pkg::RST_PINCFG;
        end else begin
          st.cfg[i] <= jk_seq_pkg::RST_LINK;
        end
      end
      st.q           <= jk_seq_pkg::Q_RESET;
      st.regOut      <= jk_seq_pkg::PIN_RESET;
      st.regOe       <= jk_seq_pkg::PIN_RESET;
      st.bioOut      <= 4'h0;
      st.bioOe       <= 4'h0;
      st.waitrequest <= 1'b1;
      st.readdata    <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  assign readdata    = st.readdata;
  assign waitrequest = st.waitrequest;
  assign regOut      = st.regOut;
  assign regOe       = st.regOe;
  assign bioOut      = st.bioOut;
  assign bioOe       = st.bioOe;

  // ==========================================================================
  // Checks
  // Flip-flops that follow their excitation this cycle
  logic [7:0] arrayRun;
  logic [1:0] mode0;
  assign arrayRun = ~presetF & ~resetF & ~loadPin & {8{~diagMode}};
  assign mode0    = st.cfg[jk_seq_pkg::IDX_MODE][1:0];

  a_power_on_pins: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(resetn) |-> (regOut == 8'hFF && st.q == 8'h00))
    else $error("registered pins not one after power-on");

  a_pins_inverse: assert property (@(posedge core_clk) disable iff (!resetn)
    (regOut == ~st.q))
    else $error("registered pins not inverse of state");

  a_enable_floats: assert property (@(posedge core_clk) disable iff (!resetn)
    oeN |=> (regOe == 8'h00))
    else $error("registered pins driven with enable high");

  a_diag_load: assert property (@(posedge core_clk) disable iff (!resetn)
    diagMode |=> (st.q == ~$past(regIn) && bioOe == 4'h0))
    else $error("diagnostic load failed");

  a_preset_wins: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && presetF[0] && resetF[0]) |=> st.q[0])
    else $error("preset and reset together not high");

  a_reset_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && !presetF[4] && resetF[4]) |=> !st.q[4])
    else $error("reset did not clear state");

  a_jk_toggle: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && !presetF[1] && !resetF[1] && !loadPin[1] && jIn[1] && kIn[1]
     && st.cfg[jk_seq_pkg::IDX_MODE][3:2] == 2'h1) |=> (st.q[1] != $past(st.q[1])))
    else $error("J-K toggle failed");

  a_preload_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && !presetF[0] && !resetF[0] && loadPin[0] && oeN) |=> (st.q[0] == !$past(regIn[0])))
    else $error("preload did not take pin value");

  a_line_polarity: assert property (@(posedge core_clk) disable iff (!resetn)
    !diagMode |=> (bioOut == ($past(bSum) ^ $past(pol))))
    else $error("line output polarity wrong");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!resetn)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");

  a_jk_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h1 && !jIn[0] && !kIn[0]) |=> $stable(st.q[0]))
    else $error("J-K hold changed state");

  a_jk_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h1 && !jIn[0] && kIn[0]) |=> !st.q[0])
    else $error("J-K clear failed");

  a_jk_set: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h1 && jIn[0] && !kIn[0]) |=> st.q[0])
    else $error("J-K set failed");

  a_d_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h0) |=> (st.q[0] == $past(jIn[0])))
    else $error("D mode did not follow input");

  a_t_toggle: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h3) |=> (st.q[0] == ($past(st.q[0]) ^ $past(jIn[0]))))
    else $error("T mode toggle failed");

  a_dynamic_d: assert property (@(posedge core_clk) disable iff (!resetn)
    (arrayRun[0] && mode0 == 2'h2 && ctl[jk_seq_pkg::CTL_FC]) |=> (st.q[0] == $past(jIn[0])))
    else $error("switched D mode did not follow input");

  a_preset_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && presetF[4]) |=> st.q[4])
    else $error("preset did not set state");

  a_preset_low: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && presetF[3]) |=> st.q[3])
    else $error("low group preset did not set state");

  a_pair_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (!diagMode && !presetF[1] && !resetF[1] && loadPin[1]) |=> (st.q[1] == !$past(regIn[1])))
    else $error("paired preload did not take pin value");

  a_pins_enabled: assert property (@(posedge core_clk) disable iff (!resetn)
    (!oeN && !diagMode) |=>
    (regOe == $past(st.cfg[jk_seq_pkg::IDX_PINCFG][jk_seq_pkg::PINCFG_OE_LSB +: 8])))
    else $error("registered pin enables not per output select");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (read && waitrequest && int'(address) > jk_seq_pkg::IDX_STATUS) |=>
    (readdata == jk_seq_pkg::UNMAPPED))
    else $error("unmapped word did not read zero");

  a_status_live: assert property (@(posedge core_clk) disable iff (!resetn)
    (read && waitrequest && int'(address) == jk_seq_pkg::IDX_STATUS) |=>
    (readdata[7:0] == $past(st.q)))
    else $error("status word not live state");

  a_wait_idle: assert property (@(posedge core_clk) disable iff (!resetn)
    (!read && !write) |=> waitrequest)
    else $error("waitrequest low without request");

endmodule : programmable_jk_register_sequencer

// >>> board_logic_model.sv
// Board logic around the sequencer: pull-ups, forced pin levels, line drivers.
// Assumes the bench changes force controls just after a rising clock edge.
`timescale 1ns/10ps
module board_logic_model (
  input  wire logic [7:0] regOut,    // Registered pin drive values
  input  wire logic [7:0] regOe,     // Registered pin drive enables
  input  wire logic [3:0] bioOut,    // Line drive values
  input  wire logic [3:0] bioOe,     // Line drive enables
  input  wire logic [7:0] forceEn,   // Board drives a registered pin
  input  wire logic [7:0] forceVal,  // Level forced on that pin
  input  wire logic [3:0] bioDrv,    // Level the board puts on undriven lines
  output logic      [7:0] regIn,     // Resolved registered pin levels
  output logic      [3:0] bioIn      // Resolved line levels
);
  // ==========================================================================
  // Pin resolution; two drivers that disagree give an unknown level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (regOe[i] && forceEn[i] && (regOut[i] !== forceVal[i])) begin
        regIn[i] = 1'bx;
      end else if (regOe[i]) begin
        regIn[i] = regOut[i];
      end else if (forceEn[i]) begin
        regIn[i] = forceVal[i];
      end else begin
        regIn[i] = 1'b1;
      end
    end
    for (int j = 0; j < 4; j++) begin
      bioIn[j] = bioOe[j] ? bioOut[j] : bioDrv[j];
    end
  end
endmodule : board_logic_model

// >>> programmable_jk_register_sequencer_bench.sv
// Self-checking bench for the registered logic sequencer.
// Assumes the board model resolves the pins; bus is word-addressed Avalon-MM.
`timescale 1ns/10ps
module programmable_jk_register_sequencer_bench;
  // ==========================================================================
  // Signals and tables
  logic        core_clk;
  logic        resetn;
  logic [6:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  dinPin;
  logic [3:0]  bioIn;
  logic [3:0]  bioOut;
  logic [3:0]  bioOe;
  logic [7:0]  regIn;
  logic [7:0]  regOut;
  logic [7:0]  regOe;
  logic        oeN;
  logic        diagMode;
  logic [7:0]  forceEn;
  logic [7:0]  forceVal;
  logic [3:0]  bioDrv;
  logic [31:0] rd;
  logic [1:0]  lastMode;
  int          num_errors;
  int          total_checks;
  typedef struct {logic [6:0] a; logic wr; logic [31:0] d; logic [31:0] e;} reg_row_t;
  typedef struct {logic [1:0] mode; logic [3:0] din; logic q;} ff_row_t;
  reg_row_t    regRows [9] = '{
    '{7'h00, 1'b0, 32'h0, 32'hFFFFFFFF}, '{7'h2D, 1'b0, 32'h0, 32'hFFFFFFFF},
    '{7'h41, 1'b0, 32'h0, 32'h00000000}, '{7'h43, 1'b0, 32'h0, 32'h00000000},
    '{7'h44, 1'b0, 32'h0, 32'h00000FF0}, '{7'h45, 1'b0, 32'h0, 32'h00FF0A00},
    '{7'h46, 1'b1, 32'h12345678, 32'h0}, '{7'h03, 1'b1, 32'h0000A5A5, 32'h0000A5A5},
    '{7'h03, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF}};
  ff_row_t     ffRows [13] = '{
    '{2'h1, 4'h1, 1'b1}, '{2'h1, 4'h0, 1'b1}, '{2'h1, 4'h2, 1'b0}, '{2'h1, 4'h3, 1'b1},
    '{2'h1, 4'h3, 1'b0}, '{2'h3, 4'h1, 1'b1}, '{2'h3, 4'h1, 1'b0}, '{2'h3, 4'h0, 1'b0},
    '{2'h2, 4'h1, 1'b1}, '{2'h2, 4'h0, 1'b1}, '{2'h2, 4'h4, 1'b0}, '{2'h0, 4'h1, 1'b1},
    '{2'h0, 4'h0, 1'b0}};
  logic [11:0] prRows [5] = '{12'h400, 12'hC00, 12'h8FF, 12'hC00, 12'h400};

  programmable_jk_register_sequencer dut_u (
    .core_clk(core_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .dinPin(dinPin), .bioIn(bioIn), .bioOut(bioOut),
    .bioOe(bioOe), .regIn(regIn), .regOut(regOut), .regOe(regOe), .oeN(oeN),
    .diagMode(diagMode));
  board_logic_model board_u (
    .regOut(regOut), .regOe(regOe), .bioOut(bioOut), .bioOe(bioOe), .forceEn(forceEn),
    .forceVal(forceVal), .bioDrv(bioDrv), .regIn(regIn), .bioIn(bioIn));

  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus_req(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus_req

  // Drives the inputs for one sampling edge, then the rest level
  task automatic apply(input logic [3:0] d, input logic [3:0] rest);
    @(posedge core_clk);
    dinPin <= d;
    @(posedge core_clk);
    dinPin <= rest;
    #1;
  endtask : apply

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Clock, watchdog, main sequence
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #(4000 * 20);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    address = 7'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    dinPin = 4'h0;
    oeN = 1'b0;
    diagMode = 1'b0;
    forceEn = 8'h00;
    forceVal = 8'h00;
    bioDrv = 4'hA;
    lastMode = 2'h0;
    repeat (2) @(posedge core_clk);
    #1;
    check("regOut in reset", regOut, 8'hFF);
    check("regOe in reset", regOe, 8'hFF);
    check("bioOe in reset", bioOe, 4'h0);
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (regRows[i]) begin
      if (regRows[i].wr) begin
        bus_req(1'b1, regRows[i].a, regRows[i].d);
      end
      bus_req(1'b0, regRows[i].a, 32'h0);
      check("register word", rd, regRows[i].e);
    end
    $display("test registers done");
    bus_req(1'b1, 7'd0, 32'h00000001);
    bus_req(1'b1, 7'd1, 32'h00000002);
    bus_req(1'b1, 7'd45, 32'h00000001);
    bus_req(1'b1, 7'd53, 32'h00000002);
    bus_req(1'b1, 7'd36, 32'h00000004);
    foreach (ffRows[i]) begin
      if (ffRows[i].mode != lastMode) begin
        bus_req(1'b1, 7'd67, {16{ffRows[i].mode}});
      end
      lastMode = ffRows[i].mode;
      apply(ffRows[i].din, 4'h0);
      check("state pin 0", regOut[0], !ffRows[i].q);
    end
    $display("test flip-flop modes done");
    bus_req(1'b1, 7'd37, 32'h0);
    bus_req(1'b1, 7'd61, 32'h00000001);
    for (int p = 0; p < 2; p++) begin
      bus_req(1'b1, 7'd68, {31'h000007F8, p[0]});
      apply(4'h1, 4'h1);
      check("line 0 enable", bioOe[0], 1'b1);
      check("line 0 value", bioOut[0], !p[0]);
    end
    $display("test lines done");
    @(posedge core_clk);
    oeN <= 1'b1;
    @(posedge core_clk);
    diagMode <= 1'b1;
    forceEn <= 8'hFF;
    forceVal <= 8'hA5;
    @(posedge core_clk);
    #1;
    check("line drive in diag", bioOe, 4'h0);
    check("pins off", regOe, 8'h00);
    bus_req(1'b0, 7'd69, 32'h0);
    check("diag state", rd[7:0], 8'h5A);
    $display("test diagnostic load done");
    diagMode <= 1'b0;
    forceVal <= 8'h02;
    dinPin <= 4'h8;
    bus_req(1'b1, 7'd41, 32'h00000008);
    bus_req(1'b0, 7'd69, 32'h0);
    check("preload state", rd[7:0], 8'h01);
    check("preload pin values", regOut[1:0], 2'b10);
    forceEn <= 8'h00;
    oeN <= 1'b0;
    dinPin <= 4'h0;
    bus_req(1'b1, 7'd41, 32'hFFFFFFFF);
    bus_req(1'b1, 7'd37, 32'hFFFFFFFF);
    $display("test preload done");
    bus_req(1'b1, 7'd32, 32'h00000004);
    bus_req(1'b1, 7'd33, 32'h00000008);
    bus_req(1'b1, 7'd34, 32'h00000004);
    bus_req(1'b1, 7'd35, 32'h00000008);
    foreach (prRows[i]) begin
      apply(prRows[i][11:8], prRows[i][11:8]);
      check("preset reset pins", regOut, prRows[i][7:0]);
    end
    $display("test preset reset done");
    @(posedge core_clk);
    resetn <= 1'b0;
    #1;
    check("pins at second reset", regOut, 8'hFF);
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    dinPin <= 4'h0;
    bus_req(1'b0, 7'd32, 32'h0);
    check("config after reset", rd, 32'hFFFFFFFF);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : programmable_jk_register_sequencer_bench
